// ===== rtl/acc_pkg.sv
// acc_pkg: register map, field layouts and carrier types for the
// four-comparator control block.
// assumes an APB slave with 32-bit data and one aligned word per register.
package acc_pkg;

   localparam int ACC_N      = 4;
   localparam int ACC_NSRC   = 7;
   localparam int ACC_NAMP   = 3;
   localparam int ACC_RAW_W  = (ACC_N + ACC_NAMP) * ACC_NSRC;
   localparam int ACC_AMP_LO = ACC_N * ACC_NSRC;

   // byte offsets on the bus
   localparam logic [7:0] ACC_CTRL0_OFS  = 8'h00;
   localparam logic [7:0] ACC_CTRL1_OFS  = 8'h04;
   localparam logic [7:0] ACC_CTRL2_OFS  = 8'h08;
   localparam logic [7:0] ACC_CTRL3_OFS  = 8'h0c;
   localparam logic [7:0] ACC_STATUS_OFS = 8'h10;
   localparam logic [7:0] ACC_CONFIG_OFS = 8'h14;
   localparam logic [7:0] ACC_MASK_OFS   = 8'h18;

   // values after reset
   localparam logic [7:0] ACC_CTRL_RST   = 8'h00;
   localparam logic [6:0] ACC_CONFIG_RST = 7'h00;
   localparam logic [3:0] ACC_MASK_RST   = 4'h0;

   // writable bits of a control register; bit 3 only exists on 0 and 1
   localparam logic [7:0] ACC_CTRL_WMASK_LO = 8'hff;
   localparam logic [7:0] ACC_CTRL_WMASK_HI = 8'hf7;

   // status layout: results low nibble, sticky flags high nibble
   localparam int ACC_STAT_RES_LSB  = 0;
   localparam int ACC_STAT_FLAG_LSB = 4;
   // mask register uses the flag positions of the status register
   localparam int ACC_MASK_LSB      = 4;

   typedef enum logic [1:0] {
      ACC_SENS_TOGGLE = 2'b00,
      ACC_SENS_RSVD   = 2'b01,
      ACC_SENS_FALL   = 2'b10,
      ACC_SENS_RISE   = 2'b11
   } acc_sens_t;

   localparam logic [2:0] ACC_NSEL_RSVD = 3'b111;

   // one comparator control register
   typedef struct packed {
      logic      on;
      logic      irq_allow;
      acc_sens_t sens;
      logic      opt;    // clock source on 0, capture route on 1
      logic [2:0] nsel;
   } acc_ctrl_t;

   // shared configuration register
   typedef struct packed {
      logic [1:0] adc_ref;
      logic [2:0] amp_route;
      logic       cap_edge;
      logic       halve;
   } acc_cfg_t;

   typedef struct packed {
      logic [7:0]  paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } acc_apb_req_t;

endpackage : acc_pkg

// ===== rtl/acc_comparators.sv
// acc_comparators: digital control of four clocked comparators with an
// APB register file, sticky flags, interrupt and timer capture routing.
// assumes analog front ends that report, per negative source, whether
// the positive input is above it; tick inputs are sys_clk enables.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps

// Overview of operation
// - result high when positive exceeds selected negative
// - sample on I/O clock tick or half
// - per-comparator interrupt, rise fall or toggle
// - flags drive conversion triggers regardless of enable
// - comparator 1 may trigger timer input capture
// - separate controls, one shared status register
// - amplifier route swaps positive input and clock
// - bit 7 enables each comparator
// - bit 6 gates the interrupt request
// - bits 5:4 pick toggle, reserved, fall, rise
// - comparator 0 bit 3 selects PLL clock
// - bits 2:0 select the negative input
// - reference ladder follows the ADC reference select
// - comparator 1 has its own enable
// - codes 011 and 100 give ladder/1.60, bandgap
// - comparator 1 bit 3 routes to capture
// - capture edge follows the capture edge select
module acc_comparators (
   input  wire logic                     sys_clk,
   input  wire logic                     rst_n,
   input  wire acc_pkg::acc_apb_req_t    apb_req,
   output logic [31:0]                   prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic [3:0][6:0]          pos_above,
   input  wire logic [2:0][6:0]          amp_above,
   input  wire logic [2:0]               amp_tick,
   input  wire logic                     pll_tick,
   output logic [3:0]                    comparator_on,
   output logic [3:0][2:0]               negative_selector,
   output logic [1:0]                    ladder_ref_select,
   output logic [3:0]                    comparator_result,
   output logic [3:0]                    conv_trigger,
   output logic                          capture_input,
   output logic                          capture_event,
   output logic                          irq
);
   import acc_pkg::*;

   function automatic logic acc_trigger(input acc_sens_t sens,
                                        input logic      cur,
                                        input logic      prev);
      logic hit;
      hit = 1'b0;
      unique case (sens)
         ACC_SENS_TOGGLE: hit = cur ^ prev;
         ACC_SENS_FALL:   hit = prev & ~cur;
         ACC_SENS_RISE:   hit = cur & ~prev;
         ACC_SENS_RSVD:   hit = 1'b0;
      endcase
      return hit;
   endfunction : acc_trigger

   // index of the above-bit for each negative code; 111 has none
   function automatic logic acc_pick(input logic [6:0] above,
                                     input logic [2:0] nsel);
      logic v;
      v = 1'b0;
      if (nsel != ACC_NSEL_RSVD) begin
         v = above[nsel];
      end
      return v;
   endfunction : acc_pick

   function automatic logic [7:0] acc_ctrl_ofs(input int i);
      logic [7:0] o;
      o = ACC_CTRL0_OFS;
      unique case (i)
         1:       o = ACC_CTRL1_OFS;
         2:       o = ACC_CTRL2_OFS;
         3:       o = ACC_CTRL3_OFS;
         default: o = ACC_CTRL0_OFS;
      endcase
      return o;
   endfunction : acc_ctrl_ofs

   acc_ctrl_t              ctrl_q [ACC_N];
   acc_cfg_t               cfg_q;
   logic [3:0]             mask_q;
   logic [3:0]             flag_q;
   logic [3:0]             res_q;
   logic [3:0]             res_d;
   logic [3:0]             res_prev_q;
   logic [3:0]             set_ev;
   logic [3:0]             tick;
   logic [ACC_RAW_W-1:0]   raw_s1_q;
   logic [ACC_RAW_W-1:0]   raw_s2_q;
   logic [ACC_RAW_W-1:0]   raw_s3_q;
   logic [ACC_RAW_W-1:0]   raw_f_q;
   logic                   div_q;
   logic                   io_tick;
   logic [31:0]            rdata;
   logic                   mapped;
   logic                   setup;
   logic                   wr_en;
   logic [3:0]             flag_clr;
   logic [31:0]            prdata_q;
   logic                   pready_q;
   logic                   pslverr_q;
   logic                   cap_in_q;
   logic                   cap_ev_q;
   logic                   irq_q;
   logic [3:0]             allow_s;

   // ---------------- APB slave ----------------
   assign setup = apb_req.psel & ~apb_req.penable;
   assign wr_en = apb_req.psel & apb_req.penable & pready_q
                  & apb_req.pwrite & ~pslverr_q;

   always_comb begin
      mapped = 1'b0;
      rdata  = 32'h0000_0000;
      for (int i = 0; i < ACC_N; i++) begin
         if (apb_req.paddr == acc_ctrl_ofs(i)) begin
            mapped     = 1'b1;
            rdata[7:0] = ctrl_q[i];
         end
      end
      unique case (apb_req.paddr)
         ACC_STATUS_OFS: begin
            mapped = 1'b1;
            rdata[ACC_STAT_RES_LSB +: 4]  = res_q;
            rdata[ACC_STAT_FLAG_LSB +: 4] = flag_q;
         end
         ACC_CONFIG_OFS: begin
            mapped     = 1'b1;
            rdata[6:0] = cfg_q;
         end
         ACC_MASK_OFS: begin
            mapped = 1'b1;
            rdata[ACC_MASK_LSB +: 4] = mask_q;
         end
         default: ;
      endcase
   end

   // zero wait states: answer prepared in the setup cycle
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup & ~mapped;
         if (setup) begin
            prdata_q <= apb_req.pwrite ? 32'h0000_0000 : rdata;
         end
      end
   end

   // ---------------- registers ----------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < ACC_N; i++) begin
            ctrl_q[i] <= ACC_CTRL_RST;
         end
      end else if (wr_en) begin
         for (int i = 0; i < ACC_N; i++) begin
            if (apb_req.paddr == acc_ctrl_ofs(i)) begin
               // bit 3 of comparators 2 and 3 is reserved, reads zero
               ctrl_q[i] <= apb_req.pwdata[7:0]
                            & ((i < 2) ? ACC_CTRL_WMASK_LO
                                       : ACC_CTRL_WMASK_HI);
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cfg_q  <= ACC_CONFIG_RST;
         mask_q <= ACC_MASK_RST;
      end else if (wr_en) begin
         if (apb_req.paddr == ACC_CONFIG_OFS) begin
            cfg_q <= apb_req.pwdata[6:0];
         end
         if (apb_req.paddr == ACC_MASK_OFS) begin
            mask_q <= apb_req.pwdata[ACC_MASK_LSB +: 4];
         end
      end
   end

   // ---------------- input synchroniser ----------------
   // a bit changes only once stages two and three agree, filtering
   // single-cycle glitches from the comparator cores
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         raw_s1_q <= '0;
         raw_s2_q <= '0;
         raw_s3_q <= '0;
         raw_f_q  <= '0;
      end else begin
         raw_s1_q <= {amp_above, pos_above};
         raw_s2_q <= raw_s1_q;
         raw_s3_q <= raw_s2_q;
         for (int b = 0; b < ACC_RAW_W; b++) begin
            if (raw_s2_q[b] == raw_s3_q[b]) begin
               raw_f_q[b] <= raw_s3_q[b];
            end
         end
      end
   end

   // ---------------- sampling clocks ----------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         div_q <= 1'b0;
      end else begin
         div_q <= ~div_q;
      end
   end

   assign io_tick = cfg_q.halve ? div_q : 1'b1;

   always_comb begin
      logic [3:0] route;
      logic [3:0] atick;
      route = {1'b0, cfg_q.amp_route};
      atick = {1'b0, amp_tick};
      for (int i = 0; i < ACC_N; i++) begin
         if (route[i]) begin
            tick[i] = atick[i];
         end else if (i == 0 && ctrl_q[0].opt) begin
            tick[i] = pll_tick;
         end else begin
            tick[i] = io_tick;
         end
      end
   end

   // ---------------- comparison results ----------------
   always_comb begin
      logic [3:0] route;
      logic [6:0] above;
      route = {1'b0, cfg_q.amp_route};
      above = 7'h00;
      for (int i = 0; i < ACC_N; i++) begin
         if (route[i]) begin
            above = raw_f_q[ACC_AMP_LO + i * ACC_NSRC +: ACC_NSRC];
         end else begin
            above = raw_f_q[i * ACC_NSRC +: ACC_NSRC];
         end
         if (!ctrl_q[i].on) begin
            res_d[i] = 1'b0;
         end else if (ctrl_q[i].nsel == ACC_NSEL_RSVD) begin
            res_d[i] = 1'b0;
         end else if (tick[i]) begin
            res_d[i] = acc_pick(above, ctrl_q[i].nsel);
         end else begin
            res_d[i] = res_q[i];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         res_q      <= 4'h0;
         res_prev_q <= 4'h0;
      end else begin
         res_q      <= res_d;
         res_prev_q <= res_q;
      end
   end

   // ---------------- flags and interrupt ----------------
   always_comb begin
      for (int i = 0; i < ACC_N; i++) begin
         set_ev[i] = ctrl_q[i].on
                     & (ctrl_q[i].nsel != ACC_NSEL_RSVD)
                     & acc_trigger(ctrl_q[i].sens, res_q[i],
                                   res_prev_q[i]);
      end
   end

   assign flag_clr = (wr_en && apb_req.paddr == ACC_STATUS_OFS)
                     ? apb_req.pwdata[ACC_STAT_FLAG_LSB +: 4] : 4'h0;

   // set beats a simultaneous write-one clear
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         flag_q <= 4'h0;
      end else begin
         flag_q <= (flag_q & ~flag_clr) | set_ev;
      end
   end

   always_comb begin
      for (int i = 0; i < ACC_N; i++) begin
         allow_s[i] = ctrl_q[i].irq_allow;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(flag_q & mask_q & allow_s);
      end
   end

   // ---------------- timer capture route ----------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cap_in_q <= 1'b0;
         cap_ev_q <= 1'b0;
      end else begin
         cap_in_q <= ctrl_q[1].opt & res_q[1];
         cap_ev_q <= ctrl_q[1].opt
                     & (cfg_q.cap_edge ? (res_q[1] & ~res_prev_q[1])
                                       : (res_prev_q[1] & ~res_q[1]));
      end
   end

   // ---------------- outputs ----------------
   always_comb begin
      for (int i = 0; i < ACC_N; i++) begin
         comparator_on[i]     = ctrl_q[i].on;
         negative_selector[i] = ctrl_q[i].nsel;
      end
   end

   assign ladder_ref_select = cfg_q.adc_ref;
   assign comparator_result = res_q;
   assign conv_trigger      = flag_q;
   assign capture_input     = cap_in_q;
   assign capture_event     = cap_ev_q;
   assign irq               = irq_q;
   assign prdata            = prdata_q;
   assign pready            = pready_q;
   assign pslverr           = pslverr_q;

   // ---------------- assertions ----------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence bus_setup_s;
      apb_req.psel && !apb_req.penable;
   endsequence

   sequence bus_access_s;
      apb_req.psel && apb_req.penable;
   endsequence

   apb_ready_a: assert property (bus_setup_s ##1 bus_access_s
                                 |-> pready)
      else $error("pready missing in access phase");

   apb_unmapped_a: assert property (bus_setup_s
                                    ##0 (apb_req.paddr > ACC_MASK_OFS)
                                    |=> pslverr)
      else $error("unmapped address not flagged");

   // only while halving stays selected; a config write may end it
   halve_tick_a: assert property (cfg_q.halve && io_tick
                                  ##1 cfg_q.halve |-> !io_tick)
      else $error("halved comparison clock not every other cycle");

   irq_level_a: assert property (irq |-> $past(|(flag_q & mask_q)))
      else $error("interrupt without a masked-in flag");

   for (genvar g = 0; g < ACC_N; g++) begin : g_chk
      off_result_a: assert property (!ctrl_q[g].on |=> !res_q[g])
         else $error("disabled comparator shows a result");

      rsvd_sens_a: assert property (ctrl_q[g].sens == ACC_SENS_RSVD
                                    && !flag_q[g] |=> !flag_q[g])
         else $error("reserved sensitivity set a flag");

      flag_hold_a: assert property (flag_q[g] && flag_clr[g] == 1'b0
                                    |=> flag_q[g])
         else $error("flag dropped without a clear");

      rise_flag_a: assert property (ctrl_q[g].on
                                    && ctrl_q[g].sens == ACC_SENS_RISE
                                    && ctrl_q[g].nsel != ACC_NSEL_RSVD
                                    && res_q[g] && !res_prev_q[g]
                                    |=> flag_q[g]
                                        && conv_trigger[g])
         else $error("rising result did not set the flag");
   end

   capture_edge_a: assert property (ctrl_q[1].opt && cfg_q.cap_edge
                                    && $rose(res_q[1])
                                    |=> capture_event)
      else $error("rising capture event missed");

   capture_off_a: assert property (!ctrl_q[1].opt |=> !capture_input
                                   && !capture_event)
      else $error("capture path active while not routed");

endmodule : acc_comparators

// ===== verif/tb_top.sv
// tb_top: self-checking bench for the four-comparator control block.
// assumes acc_pkg is compiled first; the bench drives APB and all
// analog-side inputs itself and keeps a small reference model.
`timescale 1ns/1ps

`define CHK(got, exp) begin \
   checks++; \
   if ((got) !== (exp)) begin \
      fail_count++; \
      $display("[ERR] t=%0t got %h exp %h", $time, (got), (exp)); \
   end \
end

module tb_top;
   import acc_pkg::*;

   logic                sys_clk = 1'b0;
   logic                rst_n   = 1'b0;
   acc_apb_req_t        req     = '0;
   logic [31:0]         prdata;
   logic                pready;
   logic                pslverr;
   logic [3:0][6:0]     pos_above = '0;
   logic [2:0][6:0]     amp_above = '0;
   logic [2:0]          amp_tick  = '0;
   logic                pll_tick  = 1'b0;
   logic [3:0]          comparator_on;
   logic [3:0][2:0]     negative_selector;
   logic [1:0]          ladder_ref_select;
   logic [3:0]          comparator_result;
   logic [3:0]          conv_trigger;
   logic                capture_input;
   logic                capture_event;
   logic                irq;
   logic [1:0]          tick_cnt  = '0;
   int                  fail_count = 0;
   int                  checks     = 0;
   int                  seed       = 25;
   int                  cap_cnt    = 0;
   int                  ctl[4];
   int                  cfg;
   int                  msk;
   logic [31:0]         rd_q;
   logic                err_q;

   always #20 sys_clk = ~sys_clk;

   // ticks every fourth cycle so routed clocks differ from the io tick
   always @(posedge sys_clk) begin
      tick_cnt <= tick_cnt + 2'd1;
      amp_tick <= {3{tick_cnt == 2'd0}};
      pll_tick <= (tick_cnt == 2'd2);
      if (capture_event === 1'b1) cap_cnt++;
   end

   acc_comparators dut_u (
      .sys_clk           (sys_clk),
      .rst_n             (rst_n),
      .apb_req           (req),
      .prdata            (prdata),
      .pready            (pready),
      .pslverr           (pslverr),
      .pos_above         (pos_above),
      .amp_above         (amp_above),
      .amp_tick          (amp_tick),
      .pll_tick          (pll_tick),
      .comparator_on     (comparator_on),
      .negative_selector (negative_selector),
      .ladder_ref_select (ladder_ref_select),
      .comparator_result (comparator_result),
      .conv_trigger      (conv_trigger),
      .capture_input     (capture_input),
      .capture_event     (capture_event),
      .irq               (irq)
   );

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc

   // one APB transfer; waits for pready with a bounded count
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      req.psel    <= 1'b1;
      req.penable <= 1'b0;
      req.paddr   <= a;
      req.pwrite  <= w;
      req.pwdata  <= d;
      @(posedge sys_clk);
      req.penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd_q  = prdata;
      err_q = pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
      if (n >= 50) fail_count++;
   endtask : apb

   // write and keep the model in step
   task automatic wreg(input logic [7:0] a, input int d);
      apb(1'b1, a, d);
      if (a < 8'h10) ctl[a >> 2] = d & ((a < 8'h08) ? 'hff : 'hf7);
      if (a == ACC_CONFIG_OFS) cfg = d & 'h7f;
      if (a == ACC_MASK_OFS) msk = d & 'hf0;
   endtask : wreg

   function automatic logic eres(input int i);
      logic [6:0] v;
      v = (i < 3 && cfg[2+i]) ? amp_above[i] : pos_above[i];
      return ctl[i][7] && ctl[i][2:0] != 7 && v[ctl[i][2:0]];
   endfunction : eres

   task automatic tally_and_finish;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      #(40ns * 20000);
      fail_count++;
      tally_and_finish();
   end

   initial begin
      logic [3:0] er;
      logic       ef;
      void'($random(seed));
      foreach (ctl[i]) ctl[i] = 0;
      cfg = 0;
      msk = 0;
      cyc(20);
      rst_n <= 1'b1;
      cyc(2);
      // reset values of every register
      for (int a = 0; a <= 'h18; a += 4) begin
         apb(1'b0, a[7:0], 32'h0);
         `CHK(rd_q, 32'h0)
      end
      // register access, including reserved bit 3 on 2 and 3
      for (int i = 0; i < 4; i++) begin
         wreg(8'(i * 4), $random(seed));
         apb(1'b0, 8'(i * 4), 32'h0);
         `CHK(rd_q, 32'(ctl[i]))
      end
      apb(1'b1, 8'h1c, 32'hff);
      `CHK(err_q, 1'b1)
      apb(1'b0, 8'h40, 32'h0);
      `CHK({err_q, rd_q}, 33'h100000000)
      // random results across selectors, routes and clocks
      repeat (24) begin
         for (int i = 0; i < 4; i++) wreg(8'(i * 4), $random(seed) | 'h80);
         wreg(ACC_CONFIG_OFS, $random(seed));
         @(posedge sys_clk);
         pos_above <= $random(seed);
         amp_above <= $random(seed);
         cyc(14);
         for (int i = 0; i < 4; i++) er[i] = eres(i);
         `CHK(comparator_result, er)
         `CHK(ladder_ref_select, 2'(cfg >> 5))
         `CHK(comparator_on, 4'hf)
         `CHK(negative_selector[1], 3'(ctl[1]))
         apb(1'b0, ACC_STATUS_OFS, 32'h0);
         `CHK(rd_q[3:0], er)
      end
      // every sensitivity code on rise then fall, io clock halved
      wreg(ACC_CONFIG_OFS, 'h01);
      wreg(ACC_MASK_OFS, 'hf0);
      for (int s = 0; s < 4; s++) begin
         @(posedge sys_clk);
         pos_above <= '0;
         wreg(ACC_CTRL0_OFS, 'hc0 | (s << 4));
         for (int e = 1; e >= 0; e--) begin
            cyc(14);
            apb(1'b1, ACC_STATUS_OFS, 32'hf0);
            @(posedge sys_clk);
            pos_above[0][0] <= e[0];
            cyc(14);
            ef = (s == 0) || (s == 3 && e == 1) || (s == 2 && e == 0);
            `CHK(conv_trigger[0], ef)
            `CHK(irq, ef)
            apb(1'b0, ACC_STATUS_OFS, 32'h0);
            `CHK(rd_q[7:0], {3'b000, ef, 3'b000, e[0]})
         end
      end
      // flag holds, irq follows mask and allow, clear by writing one
      wreg(ACC_CTRL0_OFS, 'h80);
      @(posedge sys_clk);
      pos_above[0][0] <= 1'b1;
      cyc(14);
      `CHK({conv_trigger[0], irq}, 2'b10)
      wreg(ACC_CTRL0_OFS, 'hc0);
      cyc(3);
      `CHK({conv_trigger[0], irq}, 2'b11)
      wreg(ACC_MASK_OFS, 'h00);
      cyc(3);
      `CHK(irq, 1'b0)
      apb(1'b1, ACC_STATUS_OFS, 32'hf0);
      cyc(3);
      `CHK(conv_trigger[0], 1'b0)
      // disabled comparator gives no result and no flag
      wreg(ACC_CTRL0_OFS, 'h00);
      cyc(3);
      `CHK({comparator_result[0], conv_trigger[0]}, 2'b00)
      // comparator 1 to timer capture, both edge selects
      for (int ed = 0; ed < 2; ed++) begin
         wreg(ACC_CONFIG_OFS, ed << 1);
         wreg(ACC_CTRL1_OFS, 'h88);
         @(posedge sys_clk);
         pos_above[1] <= '0;
         cyc(14);
         cap_cnt = 0;
         pos_above[1][0] <= 1'b1;
         cyc(14);
         `CHK(capture_input, 1'b1)
         `CHK(cap_cnt, ed)
         pos_above[1][0] <= 1'b0;
         cyc(14);
         `CHK(cap_cnt, 1)
      end
      wreg(ACC_CTRL1_OFS, 'h80);
      pos_above[1][0] <= 1'b1;
      cyc(14);
      `CHK(capture_input, 1'b0)
      tally_and_finish();
   end

endmodule : tb_top
